// ---- pom_pkg.sv ----
package pom_pkg;
  localparam int unsigned POM_IDX_W        = 12;
  localparam logic [11:0] POM_PARITY_IDX   = 12'h002;
  localparam logic [11:0] POM_TRACE_IDX    = 12'h003;
  localparam logic [11:0] POM_MAINT_IDX    = 12'h004;
  localparam logic [11:0] POM_IDX_MAX      = 12'hFFF;
  localparam logic [2:0]  POM_LAST_BIT     = 3'h7;
  localparam int unsigned POM_RDI_BIT      = 7;
  localparam int unsigned POM_REI_BIT      = 6;
  localparam int unsigned POM_LABEL_HI     = 5;
  localparam int unsigned POM_LABEL_LO     = 3;
  localparam logic [2:0]  POM_LABEL_AIS    = 3'h7;
  localparam logic [2:0]  POM_LABEL_UNEQ   = 3'h0;
  localparam int unsigned POM_MF_BIT       = 7;
  localparam int unsigned POM_TRACE_LEN    = 16;
  localparam logic [3:0]  POM_TRACE_LAST   = 4'hF;
  localparam logic [1:0]  POM_TRACE_REPEAT = 2'h2;
  localparam logic [2:0]  POM_AIS_PERSIST  = 3'h5;
  localparam logic [2:0]  POM_UNEQ_PERSIST = 3'h5;
  localparam logic [2:0]  POM_RDI_PERSIST  = 3'h5;
  localparam int unsigned POM_THR_W        = 16;
  localparam int unsigned POM_WIN_W        = 4;
  localparam logic [15:0] POM_SEC_MAX      = 16'hFFFF;
  localparam logic [3:0]  POM_WIN_MAX      = 4'hF;
endpackage

// ---- pom_persist.sv ----
`timescale 1ns/100ps
`default_nettype none
// flips its state once the condition has differed from it for COUNT ticks in a row
module pom_persist #(
  parameter logic [2:0] COUNT = 3'h5
) (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic tick,
  input  wire logic hold,
  input  wire logic cond,
  output logic      state
);
  logic [2:0] run;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= 1'b0;
      run   <= 3'h0;
    end else if (hold) begin
      state <= 1'b0;
      run   <= 3'h0;
    end else if (tick) begin
      if (cond == state) begin
        run <= 3'h0;
      end else if (run == COUNT - 3'h1) begin
        state <= cond;
        run   <= 3'h0;
      end else begin
        run <= run + 3'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- pom_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - per frame, even parity of each bit over previous frame checked against parity byte
// - each differing parity bit counts as a near-end errored block indication
// - recover 16-byte trace, publish accepted value, compare with expected trace
// - only the 16-byte multiframed trace format is handled
// - maintenance byte bit 1 is remote defect, bit 2 is remote error
// - remote defect bit 1 means remote receiver in defect, 0 normal
// - remote error bit is a far-end errored block indication
// - extract signal label, bits 3 to 5 of the maintenance byte
// - path alarm declared after 5 consecutive frames with label 111
// - path alarm cleared after 5 consecutive frames with label other than 111
// - management input disables trace mismatch detection
// - server fail or path alarm holds off unequipped, degrade, remote defect, mismatch
// - trail fail from server fail, alarm, unequipped, mismatch; degrade from degraded defect
// - degraded cause only when monitored, degraded, not unequipped, not mismatched
// - server fail cause reporting selectable, default not reported
// - remote defect cause reporting selectable, default not reported
module pom_monitor
  import pom_pkg::*;
(
  input  wire logic                       mclk,
  input  wire logic                       nrst,
  input  wire logic                       ci_d,
  input  wire logic                       ci_ck,
  input  wire logic                       ci_fs,
  input  wire logic                       incoming_server_fail,
  input  wire logic                       monitor_mode_select,
  input  wire logic                       server_fail_report_enable,
  input  wire logic                       remote_defect_report_enable,
  input  wire logic                       mismatch_detect_disable,
  input  wire logic [127:0]               expected_trace,
  input  wire logic [pom_pkg::POM_THR_W-1:0] degrade_threshold,
  input  wire logic [pom_pkg::POM_WIN_W-1:0] degrade_window_count,
  input  wire logic                       one_second,
  output logic                            trail_fail_action,
  output logic                            trail_degrade_action,
  output logic                            mismatch_fault_cause,
  output logic                            unequipped_fault_cause,
  output logic                            degraded_fault_cause,
  output logic                            remote_defect_fault_cause,
  output logic                            server_fail_fault_cause,
  output logic [127:0]                    accepted_trace,
  output logic [3:0]                      near_errored_block,
  output logic                            near_block_valid,
  output logic                            far_errored_block,
  output logic                            path_alarm_defect,
  output logic                            unequipped_defect,
  output logic                            degraded_defect,
  output logic                            remote_defect_defect,
  output logic                            trace_mismatch_defect,
  output logic [2:0]                      signal_label
);
  import pom_pkg::*;

  logic [2:0]           s1;
  logic [2:0]           s2;
  logic [2:0]           s3;
  logic                 ck_q;
  logic                 ck_rise;
  logic [2:0]           bit_cnt;
  logic [6:0]           shreg;
  logic [POM_IDX_W-1:0] byte_idx;
  logic                 byte_done;
  logic [7:0]           byte_val;
  logic [POM_IDX_W-1:0] done_idx;
  logic [7:0]           par_acc;
  logic [7:0]           par_prev;
  logic                 started;
  logic                 prev_ok;
  logic                 em_done;
  logic                 tr_done;
  logic                 ma_done;
  logic [7:0]           par_diff;
  logic                 ssf_comb;
  logic [3:0]           tr_idx;
  logic [15:0][7:0]     tr_cur;
  logic [15:0][7:0]     tr_last;
  logic [15:0][7:0]     next_full;
  logic [1:0]           tr_rep;
  logic                 tr_ok;
  logic [15:0]          sec_cnt;
  logic [3:0]           bad_run;
  logic [3:0]           good_run;
  logic                 sec_bad;
  logic                 ais_raw;
  logic                 uneq_raw;
  logic                 rdi_raw;
  logic                 far_tick;

  // three-stage sampling of the link pins; the first stage feeds only the second
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s1   <= 3'h0;
      s2   <= 3'h0;
      s3   <= 3'h0;
      ck_q <= 1'b0;
    end else begin
      s1 <= {ci_ck, ci_fs, ci_d};
      s2 <= s1;
      s3 <= s2;
      if (s2[2] == s3[2]) begin
        ck_q <= s3[2];
      end
    end
  end

  // a link clock edge counts only once stages two and three agree
  assign ck_rise = (s2[2] == s3[2]) && s3[2] && !ck_q;

  // byte assembly, aligned by the frame start marker; nothing is driven back
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bit_cnt   <= 3'h0;
      shreg     <= 7'h00;
      byte_idx  <= '0;
      byte_done <= 1'b0;
      byte_val  <= 8'h00;
      done_idx  <= '0;
    end else begin
      byte_done <= 1'b0;
      if (ck_rise) begin
        if (s3[1]) begin
          bit_cnt  <= 3'h1;
          byte_idx <= '0;
          shreg    <= {6'h00, s3[0]};
        end else if (bit_cnt == POM_LAST_BIT) begin
          bit_cnt   <= 3'h0;
          byte_done <= 1'b1;
          byte_val  <= {shreg, s3[0]};
          done_idx  <= byte_idx;
          if (byte_idx != POM_IDX_MAX) begin
            byte_idx <= byte_idx + 12'h001;
          end
        end else begin
          bit_cnt <= bit_cnt + 3'h1;
          shreg   <= {shreg[5:0], s3[0]};
        end
      end
    end
  end

  assign em_done  = byte_done && (done_idx == POM_PARITY_IDX);
  assign tr_done  = byte_done && (done_idx == POM_TRACE_IDX);
  assign ma_done  = byte_done && (done_idx == POM_MAINT_IDX);
  assign par_diff = par_prev ^ byte_val;
  assign ssf_comb = incoming_server_fail | path_alarm_defect;

  // parity over every byte of a frame, kept for the next frame's check
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      par_acc            <= 8'h00;
      par_prev           <= 8'h00;
      started            <= 1'b0;
      prev_ok            <= 1'b0;
      near_errored_block <= 4'h0;
      near_block_valid   <= 1'b0;
    end else begin
      near_block_valid <= 1'b0;
      if (byte_done) begin
        if (done_idx == '0) begin
          par_prev <= par_acc;
          par_acc  <= byte_val;
          started  <= 1'b1;
          prev_ok  <= started;
        end else begin
          par_acc <= par_acc ^ byte_val;
        end
      end
      // the first frame after reset has no complete predecessor, so it is not checked
      if (em_done && prev_ok) begin
        near_errored_block <= 4'($countones(par_diff));
        near_block_valid   <= 1'b1;
      end
    end
  end

  // maintenance byte fields
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      far_errored_block <= 1'b0;
      signal_label      <= 3'h0;
      rdi_raw           <= 1'b0;
    end else begin
      far_errored_block <= ma_done && byte_val[POM_REI_BIT];
      if (ma_done) begin
        signal_label <= byte_val[POM_LABEL_HI:POM_LABEL_LO];
        rdi_raw      <= byte_val[POM_RDI_BIT];
      end
    end
  end

  assign ais_raw  = signal_label == POM_LABEL_AIS;
  assign uneq_raw = signal_label == POM_LABEL_UNEQ;

  // each persistence filter ticks one cycle after the label was captured
  pom_persist #(.COUNT(POM_AIS_PERSIST)) u_ais (
    .clk   (mclk),
    .nrst  (nrst),
    .tick  (far_tick),
    .hold  (1'b0),
    .cond  (ais_raw),
    .state (path_alarm_defect)
  );
  pom_persist #(.COUNT(POM_UNEQ_PERSIST)) u_uneq (
    .clk   (mclk),
    .nrst  (nrst),
    .tick  (far_tick),
    .hold  (ssf_comb),
    .cond  (uneq_raw),
    .state (unequipped_defect)
  );
  pom_persist #(.COUNT(POM_RDI_PERSIST)) u_rdi (
    .clk   (mclk),
    .nrst  (nrst),
    .tick  (far_tick),
    .hold  (ssf_comb),
    .cond  (rdi_raw),
    .state (remote_defect_defect)
  );

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      far_tick <= 1'b0;
    end else begin
      far_tick <= ma_done;
    end
  end

  // multiframed trace: a set top bit marks the first byte of the 16
  always_comb begin
    next_full     = tr_cur;
    // the last byte fills element 0, the bottom bits, the same order as the expected trace
    next_full[0]  = byte_val;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tr_idx         <= 4'h0;
      tr_cur         <= '0;
      tr_last        <= '0;
      tr_rep         <= 2'h0;
      tr_ok          <= 1'b0;
      accepted_trace <= '0;
    end else if (tr_done) begin
      if (byte_val[POM_MF_BIT]) begin
        tr_cur[POM_TRACE_LAST] <= byte_val;
        tr_idx    <= 4'h1;
      end else if (tr_idx != 4'h0) begin
        tr_cur[POM_TRACE_LAST - tr_idx] <= byte_val;
        if (tr_idx == POM_TRACE_LAST) begin
          tr_idx  <= 4'h0;
          tr_last <= next_full;
          // accepted after the same value arrives in three multiframes in a row
          if (next_full != tr_last) begin
            tr_rep <= 2'h0;
          end else if (tr_rep + 2'h1 != POM_TRACE_REPEAT) begin
            tr_rep <= tr_rep + 2'h1;
          end else begin
            accepted_trace <= next_full;
            tr_ok          <= 1'b1;
          end
        end else begin
          tr_idx <= tr_idx + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      trace_mismatch_defect <= 1'b0;
    end else begin
      trace_mismatch_defect <= tr_ok && !mismatch_detect_disable && !ssf_comb
                               && (accepted_trace != expected_trace);
    end
  end

  // degrade: errored frames per second against threshold, over a run of seconds
  assign sec_bad = sec_cnt >= degrade_threshold;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sec_cnt         <= 16'h0000;
      bad_run         <= 4'h0;
      good_run        <= 4'h0;
      degraded_defect <= 1'b0;
    end else if (ssf_comb) begin
      sec_cnt         <= 16'h0000;
      bad_run         <= 4'h0;
      good_run        <= 4'h0;
      degraded_defect <= 1'b0;
    end else if (one_second) begin
      sec_cnt <= 16'h0000;
      if (sec_bad) begin
        good_run <= 4'h0;
        bad_run  <= (bad_run == POM_WIN_MAX) ? bad_run : bad_run + 4'h1;
        if (bad_run + 4'h1 >= degrade_window_count) begin
          degraded_defect <= 1'b1;
        end
      end else begin
        bad_run  <= 4'h0;
        good_run <= (good_run == POM_WIN_MAX) ? good_run : good_run + 4'h1;
        if (good_run + 4'h1 >= degrade_window_count) begin
          degraded_defect <= 1'b0;
        end
      end
    end else if (near_block_valid && near_errored_block != 4'h0 && sec_cnt != POM_SEC_MAX) begin
      sec_cnt <= sec_cnt + 16'h0001;
    end
  end

  // consequent actions and reported causes
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      trail_fail_action         <= 1'b0;
      trail_degrade_action      <= 1'b0;
      mismatch_fault_cause      <= 1'b0;
      unequipped_fault_cause    <= 1'b0;
      degraded_fault_cause      <= 1'b0;
      remote_defect_fault_cause <= 1'b0;
      server_fail_fault_cause   <= 1'b0;
    end else begin
      trail_fail_action    <= ssf_comb | unequipped_defect | trace_mismatch_defect;
      trail_degrade_action <= degraded_defect;
      unequipped_fault_cause <= monitor_mode_select & unequipped_defect;
      mismatch_fault_cause   <= monitor_mode_select & trace_mismatch_defect & !unequipped_defect;
      degraded_fault_cause   <= monitor_mode_select & degraded_defect
                                & !unequipped_defect & !trace_mismatch_defect;
      remote_defect_fault_cause <= monitor_mode_select & remote_defect_defect & !trace_mismatch_defect
                                   & !unequipped_defect & remote_defect_report_enable;
      server_fail_fault_cause   <= monitor_mode_select & ssf_comb & server_fail_report_enable;
    end
  end

  sequence s_label_frame;
    ma_done ##1 far_tick;
  endsequence

  property p_parity_check;
    @(posedge mclk) disable iff (!nrst)
      em_done && prev_ok |=> near_block_valid && near_errored_block == $countones($past(par_diff));
  endproperty
  a_parity_check: assert property (p_parity_check) else $error("parity count wrong");

  property p_no_check_first;
    @(posedge mclk) disable iff (!nrst)
      !prev_ok |=> !near_block_valid;
  endproperty
  a_no_check_first: assert property (p_no_check_first) else $error("unchecked frame flagged");

  property p_rei_bit;
    @(posedge mclk) disable iff (!nrst)
      ma_done |=> far_errored_block == $past(byte_val[POM_REI_BIT]);
  endproperty
  a_rei_bit: assert property (p_rei_bit) else $error("remote error bit wrong");

  property p_label;
    @(posedge mclk) disable iff (!nrst)
      s_label_frame |-> signal_label == $past(byte_val[POM_LABEL_HI:POM_LABEL_LO]);
  endproperty
  a_label: assert property (p_label) else $error("label not captured");

  property p_ais_set;
    @(posedge mclk) disable iff (!nrst)
      $rose(path_alarm_defect) |-> $past(ais_raw) && $past(far_tick);
  endproperty
  a_ais_set: assert property (p_ais_set) else $error("alarm raised without all-ones label");

  property p_ais_clr;
    @(posedge mclk) disable iff (!nrst)
      $fell(path_alarm_defect) |-> !$past(ais_raw) && $past(far_tick);
  endproperty
  a_ais_clr: assert property (p_ais_clr) else $error("alarm cleared on all-ones label");

  property p_holdoff;
    @(posedge mclk) disable iff (!nrst)
      ssf_comb |=> !degraded_defect && !trace_mismatch_defect && !unequipped_defect && !remote_defect_defect;
  endproperty
  a_holdoff: assert property (p_holdoff) else $error("defect not held off");

  property p_tim_dis;
    @(posedge mclk) disable iff (!nrst)
      mismatch_detect_disable |=> !trace_mismatch_defect;
  endproperty
  a_tim_dis: assert property (p_tim_dis) else $error("mismatch while disabled");

  property p_fail;
    @(posedge mclk) disable iff (!nrst)
      (incoming_server_fail || unequipped_defect || trace_mismatch_defect) |=> trail_fail_action;
  endproperty
  a_fail: assert property (p_fail) else $error("trail fail missing");

  property p_deg_cause;
    @(posedge mclk) disable iff (!nrst)
      degraded_fault_cause |-> $past(monitor_mode_select) && !$past(unequipped_defect) && !$past(trace_mismatch_defect);
  endproperty
  a_deg_cause: assert property (p_deg_cause) else $error("degrade cause unqualified");

  property p_ssf_cause;
    @(posedge mclk) disable iff (!nrst)
      !server_fail_report_enable |=> !server_fail_fault_cause;
  endproperty
  a_ssf_cause: assert property (p_ssf_cause) else $error("server fail cause unrequested");
endmodule
`default_nettype wire

// ---- pom_path_framer.sv ----
`timescale 1ns/100ps
`default_nettype none
// upstream framer: six-byte frames, link clock stands low between bursts
module pom_path_framer (
  output logic               ci_d,
  output logic               ci_ck,
  output logic               ci_fs,
  input  wire logic [7:0]    maint,
  input  wire logic [7:0]    err_mask,
  input  wire logic [127:0]  tx_trace
);
  logic [7:0] bip;
  logic [3:0] mf;

  initial begin
    ci_d = 1'b0;
    ci_ck = 1'b0;
    ci_fs = 1'b0;
    bip = 8'h00;
    mf = 4'h0;
  end

  task automatic send_frames(input int n);
    logic [7:0] fr [6];
    logic [7:0] acc;
    for (int f = 0; f < n; f++) begin
      fr[0] = 8'hF6;
      fr[1] = 8'h28;
      fr[2] = bip ^ err_mask;
      fr[3] = tx_trace[127 - 8 * mf -: 8];
      fr[4] = maint;
      fr[5] = {4'hA, mf};
      acc = 8'h00;
      for (int b = 0; b < 6; b++) begin
        acc = acc ^ fr[b];
        for (int i = 7; i >= 0; i--) begin
          ci_d = fr[b][i];
          ci_fs = (b == 0) && (i == 7);
          #160 ci_ck = 1'b1;
          #160 ci_ck = 1'b0;
        end
      end
      // parity covers the bytes as sent, corrupted parity byte included
      bip = acc;
      mf = mf + 4'h1;
      ci_fs = 1'b0;
      ci_d = ~ci_d;
    end
  endtask
endmodule
`default_nettype wire

// ---- pom_monitor_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module pom_monitor_tb_top;
  import pom_pkg::*;
  typedef struct packed {
    logic [7:0] maint;
    logic [7:0] err;
    logic       ssf;
    logic [3:0] nfr;
    logic [3:0] near;
    logic [3:0] far;
    logic [3:0] flags;
  } pom_row_t;
  // flags: path alarm, unequipped, remote defect, trail fail
  localparam pom_row_t ROWS [13] = '{
    '{8'h08, 8'h00, 1'h0, 4'h6, 4'h0, 4'h0, 4'h0},
    '{8'h48, 8'h81, 1'h0, 4'h3, 4'h2, 4'h3, 4'h0},
    '{8'h08, 8'hFF, 1'h0, 4'h2, 4'h8, 4'h0, 4'h0},
    '{8'h88, 8'h00, 1'h0, 4'h4, 4'h0, 4'h0, 4'h0},
    '{8'h88, 8'h00, 1'h0, 4'h1, 4'h0, 4'h0, 4'h2},
    '{8'h88, 8'h00, 1'h1, 4'h1, 4'h0, 4'h0, 4'h1},
    '{8'h38, 8'h00, 1'h0, 4'h4, 4'h0, 4'h0, 4'h0},
    '{8'h38, 8'h00, 1'h0, 4'h1, 4'h0, 4'h0, 4'h9},
    '{8'h08, 8'h00, 1'h0, 4'h4, 4'h0, 4'h0, 4'h9},
    '{8'h08, 8'h00, 1'h0, 4'h1, 4'h0, 4'h0, 4'h0},
    '{8'h00, 8'h00, 1'h0, 4'h4, 4'h0, 4'h0, 4'h0},
    '{8'h00, 8'h00, 1'h0, 4'h1, 4'h0, 4'h0, 4'h5},
    '{8'h08, 8'h00, 1'h0, 4'h5, 4'h0, 4'h0, 4'h0}};
  localparam logic [127:0] TR_A = 128'hC150_4F4D_2D54_5241_4345_2D41_2D30_3031;
  localparam logic [127:0] TR_B = 128'hC150_4F4D_2D54_5241_4345_2D42_2D30_3032;

  logic         mclk, nrst, incoming_server_fail, monitor_mode_select, one_second;
  logic         server_fail_report_enable, remote_defect_report_enable, mismatch_detect_disable;
  logic [127:0] expected_trace, accepted_trace, tx_trace;
  logic [15:0]  degrade_threshold;
  logic [3:0]   degrade_window_count, near_errored_block, exp_near, far_base;
  logic [3:0]   far_seen  = 4'h0;
  logic [7:0]   near_seen = 8'h00;
  logic         trail_fail_action, trail_degrade_action, mismatch_fault_cause, unequipped_fault_cause;
  logic         degraded_fault_cause, remote_defect_fault_cause, server_fail_fault_cause;
  logic         near_block_valid, far_errored_block, path_alarm_defect, unequipped_defect;
  logic         degraded_defect, remote_defect_defect, trace_mismatch_defect;
  logic [2:0]   signal_label;
  logic [7:0]   maint, err_mask;
  wire logic    ci_d, ci_ck, ci_fs;
  int           failures, cmp_count;

  pom_monitor u_pom_monitor (
    .mclk, .nrst, .ci_d, .ci_ck, .ci_fs, .incoming_server_fail, .monitor_mode_select,
    .server_fail_report_enable, .remote_defect_report_enable, .mismatch_detect_disable,
    .expected_trace, .degrade_threshold, .degrade_window_count, .one_second,
    .trail_fail_action, .trail_degrade_action, .mismatch_fault_cause, .unequipped_fault_cause,
    .degraded_fault_cause, .remote_defect_fault_cause, .server_fail_fault_cause,
    .accepted_trace, .near_errored_block, .near_block_valid, .far_errored_block,
    .path_alarm_defect, .unequipped_defect, .degraded_defect, .remote_defect_defect,
    .trace_mismatch_defect, .signal_label);

  pom_path_framer u_pom_path_framer (.ci_d, .ci_ck, .ci_fs, .maint, .err_mask, .tx_trace);

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic frames(input int n);
    u_pom_path_framer.send_frames(n);
    cyc(8);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // the near-end count is judged on the very cycle its strobe stands
  always @(posedge mclk) begin
    if (near_block_valid === 1'b1) begin
      chk(128'(near_errored_block), 128'(exp_near));
      near_seen <= near_seen + 8'h01;
    end
    if (far_errored_block === 1'b1) begin
      far_seen <= far_seen + 4'h1;
    end
  end

  initial begin
    #3000000;
    $display("watchdog expired");
    failures++;
    end_of_test();
  end

  initial begin
    failures = 0;
    cmp_count = 0;
    nrst = 1'b0;
    incoming_server_fail = 1'b0;
    monitor_mode_select = 1'b1;
    one_second = 1'b0;
    server_fail_report_enable = 1'b0;
    remote_defect_report_enable = 1'b0;
    mismatch_detect_disable = 1'b0;
    expected_trace = TR_A;
    tx_trace = TR_A;
    degrade_threshold = 16'h0001;
    degrade_window_count = 4'h2;
    maint = 8'h08;
    err_mask = 8'h00;
    exp_near = 4'h0;
    far_base = 4'h0;
    cyc(2);
    nrst = 1'b1;
    cyc(1);
    chk(128'({trail_fail_action, trail_degrade_action, path_alarm_defect}), 128'h0);
    chk(accepted_trace, 128'h0);
    for (int r = 0; r < 13; r++) begin
      maint = ROWS[r].maint;
      err_mask = ROWS[r].err;
      incoming_server_fail = ROWS[r].ssf;
      exp_near = ROWS[r].near;
      far_base = far_seen;
      frames(int'(ROWS[r].nfr));
      chk(128'(4'(far_seen - far_base)), 128'(ROWS[r].far));
      chk(128'(path_alarm_defect), 128'(ROWS[r].flags[3]));
      chk(128'(unequipped_defect), 128'(ROWS[r].flags[2]));
      chk(128'(unequipped_fault_cause), 128'(ROWS[r].flags[2]));
      chk(128'(remote_defect_defect), 128'(ROWS[r].flags[1]));
      chk(128'(trail_fail_action), 128'(ROWS[r].flags[0]));
      chk(128'(signal_label), 128'(ROWS[r].maint[5:3]));
    end
    incoming_server_fail = 1'b0;
    // two errored seconds in a row raise the degrade defect
    err_mask = 8'h01;
    exp_near = 4'h1;
    for (int s = 0; s < 2; s++) begin
      frames(1);
      one_second = 1'b1;
      cyc(1);
      one_second = 1'b0;
      cyc(3);
      chk(128'(degraded_defect), 128'(s));
    end
    err_mask = 8'h00;
    exp_near = 4'h0;
    chk(128'(trail_degrade_action), 128'h1);
    chk(128'(degraded_fault_cause), 128'h1);
    monitor_mode_select = 1'b0;
    cyc(3);
    chk(128'(degraded_fault_cause), 128'h0);
    monitor_mode_select = 1'b1;
    incoming_server_fail = 1'b1;
    cyc(3);
    chk(128'(degraded_defect), 128'h0);
    chk(128'(trail_fail_action), 128'h1);
    chk(128'(server_fail_fault_cause), 128'h0);
    server_fail_report_enable = 1'b1;
    cyc(3);
    chk(128'(server_fail_fault_cause), 128'h1);
    server_fail_report_enable = 1'b0;
    incoming_server_fail = 1'b0;
    maint = 8'h88;
    frames(5);
    chk(128'(remote_defect_fault_cause), 128'h0);
    remote_defect_report_enable = 1'b1;
    cyc(3);
    chk(128'(remote_defect_fault_cause), 128'h1);
    remote_defect_report_enable = 1'b0;
    maint = 8'h08;
    frames(16);
    chk(accepted_trace, TR_A);
    chk(128'(trace_mismatch_defect), 128'h0);
    // a new trace needs a partial multiframe plus three whole ones
    tx_trace = TR_B;
    frames(56);
    chk(accepted_trace, TR_B);
    chk(128'(trace_mismatch_defect), 128'h1);
    chk(128'(trail_fail_action), 128'h1);
    chk(128'(mismatch_fault_cause), 128'h1);
    mismatch_detect_disable = 1'b1;
    frames(16);
    chk(128'(trace_mismatch_defect), 128'h0);
    chk(128'(trail_fail_action), 128'h0);
    mismatch_detect_disable = 1'b0;
    frames(16);
    // 148 frames sent, all but the first after reset carry a parity check
    chk(128'(near_seen), 128'h93);
    nrst = 1'b0;
    cyc(2);
    chk(128'({trace_mismatch_defect, trail_fail_action}), 128'h0);
    chk(accepted_trace, 128'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
